// [logic/asc_controller.sv]
// Controller that drives an asynchronous byte-wide static memory through its pins.
//
// Contract
// [RULE_01] Memory holds 128K bytes of 8 bits.
// [RULE_02] Write: select low, select high, strobe low.
// [RULE_03] Read: selects active, output enable low, strobe high.
// [RULE_04] Memory floats data when deselected or disabled.
// [RULE_05] Either select inactive puts memory in standby.
// [RULE_06] Write interval is overlap of all three.
// [RULE_07] Write ends when first qualifier goes inactive.
// [RULE_08] Simultaneous deselect and strobe rise keeps lines floating.
// [RULE_09] Output enable high keeps data floating during write.
// [RULE_10] Controller never drives while memory may drive.
// [RULE_11] Address valid no later than selects active.
// [RULE_12] Write strobe stays high through every read.
// [RULE_13] Selected with both enables high floats data.
// [RULE_14] Address 17 bits, data 8 bits bidirectional.
`timescale 1ns/10ps
module asc_controller
    import asc_pkg::*;
(
    input wire logic clock, // System clock, 50 MHz.
    input wire logic reset, // Synchronous reset, active high.
    input wire logic request_valid, // User requests an access.
    input wire asc_request_type request, // Access kind, address and write byte.
    output logic request_ready, // Controller can take a request.
    output logic read_valid, // Read byte is ready, one cycle.
    output logic [DATA_WIDTH-1:0] read_data, // Byte read from memory.
    output logic [ADDR_WIDTH-1:0] address_lines, // Address to memory.
    output logic select_low_active_n, // Low-active chip select.
    output logic select_high_active, // High-active chip select.
    output logic output_enable_n, // Low-active output enable.
    output logic write_enable_n, // Low-active write strobe.
    input wire logic [DATA_WIDTH-1:0] data_lines_in, // Data pins as seen.
    output logic [DATA_WIDTH-1:0] data_lines_out, // Data driven to memory.
    output logic data_lines_oe // High while the controller drives data.
);

    asc_state_type state;
    asc_strobe_type strobe;
    logic timer_load;
    logic [COUNT_WIDTH-1:0] timer_value;
    logic timer_done;
    logic take;

    assign take = request_valid && request_ready;

    asc_timer u_asc_timer (
        .clock(clock),
        .reset(reset),
        .load(timer_load),
        .count_value(timer_value),
        .done(timer_done)
    );

    // Phase sequencing; recovery gives the memory time to release the bus after a read.
    always_ff @(posedge clock)
    begin
        if (reset)
            state <= ST_IDLE;
        else
        begin
            unique case (state)
                ST_IDLE:
                    if (take)
                        state <= request.write ? ST_WRITE : ST_READ;
                ST_READ:
                    if (timer_done)
                        state <= ST_RECOVER;
                ST_WRITE:
                    if (timer_done)
                        state <= ST_RECOVER;
                ST_RECOVER:
                    if (timer_done)
                        state <= ST_IDLE;
                default:
                    state <= ST_IDLE;
            endcase
        end
    end

    // Timer loads at the start of each phase.
    always_comb
    begin
        timer_load = 1'b0;
        timer_value = TURN_COUNT;
        if (state == ST_IDLE && take)
        begin
            timer_load = 1'b1;
            timer_value = request.write ? WRITE_COUNT : READ_COUNT;
        end
        else if ((state == ST_READ || state == ST_WRITE) && timer_done)
        begin
            timer_load = 1'b1;
            timer_value = TURN_COUNT;
        end
    end

    // Request handshake: accept only when idle so the address never moves mid-access.
    always_ff @(posedge clock)
    begin
        if (reset)
            request_ready <= 1'b0;
        else
            request_ready <= (state == ST_IDLE) && !take;
    end

    // Address is set in the same edge as the selects, so it is valid no later than them. [RULE_11] [RULE_14]
    always_ff @(posedge clock)
    begin
        if (reset)
            address_lines <= ADDR_RESET;
        else if (take)
            address_lines <= request.address;
    end

    // Strobes: read keeps the write strobe high; write ends with strobe and selects together. [RULE_02] [RULE_03]
    always_ff @(posedge clock)
    begin
        if (reset)
            strobe <= STROBE_IDLE;
        else if (state == ST_IDLE && take)
        begin
            strobe.select_low_active_n <= 1'b0;
            strobe.select_high_active <= 1'b1;
            strobe.output_enable_n <= request.write; // [RULE_09]
            strobe.write_enable_n <= !request.write; // [RULE_12]
        end
        else if ((state == ST_READ || state == ST_WRITE) && timer_done)
            strobe <= STROBE_IDLE; // [RULE_07] [RULE_06]
    end

    assign select_low_active_n = strobe.select_low_active_n;
    assign select_high_active = strobe.select_high_active;
    assign output_enable_n = strobe.output_enable_n;
    assign write_enable_n = strobe.write_enable_n;

    // Drive data only for writes, where output enable is high, so the memory never drives. [RULE_10]
    always_ff @(posedge clock)
    begin
        if (reset)
        begin
            data_lines_oe <= 1'b0;
            data_lines_out <= DATA_RESET;
        end
        else if (state == ST_IDLE && take)
        begin
            data_lines_oe <= request.write;
            data_lines_out <= request.data;
        end
        else if (state == ST_WRITE && timer_done)
            data_lines_oe <= 1'b0; // Data hold of zero lets drive drop with the strobe.
    end

    // Capture the byte at the end of the read phase, after the full access time. [RULE_03]
    always_ff @(posedge clock)
    begin
        if (reset)
        begin
            read_valid <= 1'b0;
            read_data <= DATA_RESET;
        end
        else
        begin
            read_valid <= (state == ST_READ) && timer_done;
            if (state == ST_READ && timer_done)
                read_data <= data_lines_in;
        end
    end

    // A write never happens with the output enable low.
    chk_write_oe_high: assert property (@(posedge clock) disable iff (reset) // [RULE_10]
        !write_enable_n |-> output_enable_n && data_lines_oe)
        else $error("write strobe low without controller drive");

    // A read keeps the write strobe high and the controller off the lines.
    chk_read_we_high: assert property (@(posedge clock) disable iff (reset) // [RULE_12]
        !output_enable_n |-> write_enable_n && !data_lines_oe)
        else $error("read with write strobe low or data driven");

    // Both selects move together, so the memory is never left half selected.
    chk_select_pair: assert property (@(posedge clock) disable iff (reset) // [RULE_02]
        select_low_active_n == !select_high_active)
        else $error("chip selects out of step");

    // The address stands still for as long as the selects stay active.
    chk_address_hold: assert property (@(posedge clock) disable iff (reset) // [RULE_11]
        !select_low_active_n && !$past(select_low_active_n) |-> $stable(address_lines))
        else $error("address moved during an access");

    // Each read or write phase opens with exactly one strobe going low.
    sequence write_start_seq;
        $fell(write_enable_n);
    endsequence

    sequence read_start_seq;
        $fell(output_enable_n);
    endsequence

    // The write pulse lasts the write count, then strobe and selects go inactive together.
    chk_write_length: assert property (@(posedge clock) disable iff (reset) // [RULE_06]
        write_start_seq |-> !write_enable_n [*3] ##1 write_enable_n && select_low_active_n)
        else $error("write pulse length wrong");

    // Drive stops on the edge where the strobe rises; a data hold of zero allows that.
    chk_write_end_float: assert property (@(posedge clock) disable iff (reset) // [RULE_07]
        $rose(write_enable_n) |-> !data_lines_oe)
        else $error("data driven after write end");

    // The byte is taken on the edge that closes the read phase.
    chk_read_length: assert property (@(posedge clock) disable iff (reset) // [RULE_03]
        read_start_seq |-> !output_enable_n [*4] ##1 output_enable_n ##0 read_valid)
        else $error("read phase length wrong");

    // Two quiet cycles after a read let the memory release the lines first.
    chk_turnaround: assert property (@(posedge clock) disable iff (reset) // [RULE_10]
        $rose(output_enable_n) |-> !data_lines_oe [*2])
        else $error("bus driven too soon after read");

    // While a request may be taken, the pins are idle and the lines are released.
    chk_ready_quiet: assert property (@(posedge clock) disable iff (reset) // [RULE_10]
        request_ready |-> select_low_active_n && output_enable_n && write_enable_n && !data_lines_oe)
        else $error("pins busy while ready");

endmodule // asc_controller

// [logic/asc_pkg.sv]
// Package with pin bundles, states and timing constants for the static memory controller.
package asc_pkg;

    localparam int ADDR_WIDTH = 17;
    localparam int DATA_WIDTH = 8;

    // Clock period in nanoseconds at 50 MHz.
    localparam int CLOCK_PERIOD_NS = 20;

    // Memory timing figures for the slower speed grade, in nanoseconds.
    localparam int READ_CYCLE_NS = 70;
    localparam int WRITE_PULSE_NS = 60;
    localparam int TURNAROUND_NS = 25;

    // Least times round up to whole cycles.
    localparam int READ_CYCLES = (READ_CYCLE_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
    localparam int WRITE_CYCLES = (WRITE_PULSE_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
    localparam int TURN_CYCLES = (TURNAROUND_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;

    localparam int COUNT_WIDTH = 3;
    localparam logic [COUNT_WIDTH-1:0] COUNT_ZERO = 3'h0;
    localparam logic [COUNT_WIDTH-1:0] COUNT_ONE = 3'h1;
    localparam logic [COUNT_WIDTH-1:0] READ_COUNT = COUNT_WIDTH'(READ_CYCLES);
    localparam logic [COUNT_WIDTH-1:0] WRITE_COUNT = COUNT_WIDTH'(WRITE_CYCLES);
    localparam logic [COUNT_WIDTH-1:0] TURN_COUNT = COUNT_WIDTH'(TURN_CYCLES);

    localparam logic [ADDR_WIDTH-1:0] ADDR_RESET = 17'h00000;
    localparam logic [DATA_WIDTH-1:0] DATA_RESET = 8'h00;

    // Controller states.
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_READ = 3'b001,
        ST_WRITE = 3'b010,
        ST_RECOVER = 3'b011
    } asc_state_type;

    // Request from the user side.
    typedef struct packed {
        logic write;
        logic [ADDR_WIDTH-1:0] address;
        logic [DATA_WIDTH-1:0] data;
    } asc_request_type;

    // Strobes driven toward the memory.
    typedef struct packed {
        logic select_low_active_n;
        logic select_high_active;
        logic output_enable_n;
        logic write_enable_n;
    } asc_strobe_type;

    localparam asc_strobe_type STROBE_IDLE = '{select_low_active_n: 1'b1, select_high_active: 1'b0,
                                               output_enable_n: 1'b1, write_enable_n: 1'b1};

endpackage

// [logic/asc_timer.sv]
// Down counter that times each phase of a memory access.
`timescale 1ns/10ps
module asc_timer
    import asc_pkg::*;
(
    input wire logic clock, // System clock.
    input wire logic reset, // Synchronous reset, active high.
    input wire logic load, // Load a new count.
    input wire logic [COUNT_WIDTH-1:0] count_value, // Count to load.
    output logic done // High when the count is at one or has run out.
);

    logic [COUNT_WIDTH-1:0] count;

    // Count down to zero after a load; a load of one ends after one cycle.
    always_ff @(posedge clock)
    begin
        if (reset)
            count <= COUNT_ZERO;
        else if (load)
            count <= count_value;
        else if (count != COUNT_ZERO)
            count <= count - COUNT_ONE;
    end

    assign done = (count == COUNT_ONE) || (count == COUNT_ZERO);

endmodule // asc_timer

// [test/asc_memory_model.sv]
// Behavioural model of the byte-wide static memory on the far side of the controller.
`timescale 1ns/10ps
module asc_memory_model
    import asc_pkg::*;
(
    address_lines, // Address from the controller.
    select_low_active_n, // Low-active chip select.
    select_high_active, // High-active chip select.
    output_enable_n, // Low-active output enable.
    write_enable_n, // Low-active write strobe.
    data_in, // Resolved data wire, slightly delayed.
    mem_data_out, // Byte the memory drives.
    mem_data_oe // High while the memory drives.
);
    input wire logic [ADDR_WIDTH-1:0] address_lines;
    input wire logic select_low_active_n;
    input wire logic select_high_active;
    input wire logic output_enable_n;
    input wire logic write_enable_n;
    input wire logic [DATA_WIDTH-1:0] data_in;
    output logic [DATA_WIDTH-1:0] mem_data_out;
    output logic mem_data_oe;

    logic [DATA_WIDTH-1:0] store [0:(1<<ADDR_WIDTH)-1];
    logic selected;
    logic write_active;

    // Either select inactive means standby, and nothing happens in the array.
    assign selected = !select_low_active_n && select_high_active;
    assign write_active = selected && !write_enable_n;

    // Drive only on a true read; deselect, disable or write all float the lines.
    assign mem_data_oe = selected && !output_enable_n && write_enable_n;
    assign mem_data_out = store[address_lines];

    // Store at the end of the write interval; the delayed wire keeps a zero hold time safe.
    always @(negedge write_active)
    begin
        store[address_lines] = data_in;
    end
endmodule // asc_memory_model

// [test/asc_controller_test.sv]
// Self-checking testbench for the static memory controller.
`timescale 1ns/10ps
module asc_controller_test;
    import asc_pkg::*;

    logic clock = 1'b0;
    logic reset = 1'b1;
    logic request_valid = 1'b0;
    asc_request_type request = '0;
    logic request_ready, read_valid, data_lines_oe, mem_data_oe;
    logic [DATA_WIDTH-1:0] read_data, data_lines_out, mem_data_out, last_driven, model_data;
    logic [ADDR_WIDTH-1:0] address_lines, prev_address;
    logic select_low_active_n, select_high_active, output_enable_n, write_enable_n, prev_selected;
    wire logic [DATA_WIDTH-1:0] data_wire;
    int num_errors = 0;
    int checks_done = 0;
    int cycles = 0;
    int low_count = 0;

    always #10 clock = ~clock;

    // A floating wire shows the inverse of the last driven byte so stale data never reads back.
    assign data_wire = data_lines_oe ? data_lines_out : (mem_data_oe ? mem_data_out : ~last_driven);
    always @(data_wire) if (data_lines_oe || mem_data_oe) last_driven = data_wire;
    assign #1 model_data = data_wire;

    asc_controller u_asc_controller (.clock(clock), .reset(reset), .request_valid(request_valid),
        .request(request), .request_ready(request_ready), .read_valid(read_valid), .read_data(read_data),
        .address_lines(address_lines), .select_low_active_n(select_low_active_n),
        .select_high_active(select_high_active), .output_enable_n(output_enable_n),
        .write_enable_n(write_enable_n), .data_lines_in(data_wire), .data_lines_out(data_lines_out),
        .data_lines_oe(data_lines_oe));

    asc_memory_model u_asc_memory_model (.address_lines(address_lines),
        .select_low_active_n(select_low_active_n), .select_high_active(select_high_active),
        .output_enable_n(output_enable_n), .write_enable_n(write_enable_n), .data_in(model_data),
        .mem_data_out(mem_data_out), .mem_data_oe(mem_data_oe));

    task check(input logic [31:0] seen, input logic [31:0] expected);
        checks_done++;
        if (seen !== expected)
        begin
            num_errors++;
            $display("[ERR] t=%0t seen=%h expected=%h", $time, seen, expected);
        end
    endtask

    task wrap_up;
        if (num_errors == 0 && checks_done > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    // Pin watcher; every figure is judged on the values that stood before the edge.
    always @(posedge clock)
    begin
        cycles++;
        if (!reset)
        begin
            check(data_lines_oe && mem_data_oe, 1'b0);
            if (!output_enable_n) check(write_enable_n, 1'b1);
            if (prev_selected && !select_low_active_n) check(address_lines, prev_address);
            if (!write_enable_n)
            begin
                check({output_enable_n, select_low_active_n, select_high_active}, 3'h5);
                low_count++;
            end
            else if (low_count != 0)
            begin
                check(low_count, WRITE_CYCLES);
                low_count = 0;
            end
        end
        prev_selected = !select_low_active_n && select_high_active;
        prev_address = address_lines;
        // The ceiling is far above the fewer than two hundred cycles that the scenarios need.
        if (cycles == 5000)
        begin
            num_errors++;
            wrap_up;
        end
    end

    // One access; a read answers when its read phase has run out, for one cycle only.
    task access(input logic wr, input logic [16:0] addr, input logic [7:0] data, input logic [7:0] expect_data);
        int n;
        n = 0;
        while (request_ready !== 1'b1) begin @(posedge clock); #1; end
        request_valid = 1'b1;
        request = '{wr, addr, data};
        @(posedge clock);
        #1;
        request_valid = 1'b0;
        if (!wr)
        begin
            while (read_valid !== 1'b1 && n < 10) begin @(posedge clock); #1; n++; end
            check(n, READ_CYCLES);
            check(read_data, expect_data);
            @(posedge clock);
            #1;
            check(read_valid, 1'b0);
        end
    endtask

    // Both ends of the address space hold distinct bytes.
    task run_boundary;
        access(1'b1, 17'h1FFFF, 8'hA5, 8'h00);
        access(1'b1, 17'h00000, 8'h5A, 8'h00);
        access(1'b0, 17'h1FFFF, 8'h00, 8'hA5);
        access(1'b0, 17'h00000, 8'h00, 8'h5A);
    endtask

    // Walking the even address bits 0 to 14 catches a stuck or swapped line among them.
    task run_walk;
        for (int i = 1; i < 9; i++) access(1'b1, 17'h1 << (2 * i - 2), 8'(i * 8'h1D), 8'h00);
        for (int i = 8; i > 0; i--) access(1'b0, 17'h1 << (2 * i - 2), 8'h00, 8'(i * 8'h1D));
    endtask

    // A request made while busy is ignored and must not reach the array.
    task run_refused;
        access(1'b0, 17'h1FFFF, 8'h00, 8'hA5);
        check(request_ready, 1'b0);
        request_valid = 1'b1;
        request = '{1'b1, 17'h00000, 8'hFF};
        @(posedge clock);
        #1;
        request_valid = 1'b0;
        access(1'b0, 17'h00000, 8'h00, 8'h5A);
    endtask

    initial
    begin
        repeat (8) @(posedge clock);
        #1;
        reset = 1'b0;
        check({select_low_active_n, select_high_active, output_enable_n, write_enable_n, data_lines_oe}, 5'h16);
        run_boundary;
        run_walk;
        run_refused;
        repeat (10) @(posedge clock);
        wrap_up;
    end
endmodule // asc_controller_test
